/* File: logic/frs_flash_read_status.v */
// Purpose: read path and status word of a two-array flash
// Assumes: array data and sequencer events come in through registers
// Notes: software emulates the parallel host bus through the BUS word
// Operation
// R1: reset or reset command gives read-array mode
// R2: plain reads return stored array data
// R3: identifier mode read returns fixed identifier
// R4: protection read returns one or zero
// R5: protection bits readable as a register
// R6: busy reads return status, no side effect
// R7: poll 7, toggle 6, error 5, window 3
// R8: host raises sector select when reading status; here every port read counts as selected
// R9: program polling bit is inverted data bit
// R10: polling valid after fourth or sixth write
// R11: erase polling reads zero, then one
// R12: program into protected sector is ignored
// R13: all-protected erase: zero for about 100 us
// R14: toggle inverts each selected read while busy
// R15: done: toggle stops, data returns
// R16: toggle valid after fourth or sixth write
// R17: host sees done on two equal reads
// R18: all-protected erase toggles about 100 us
// R19: error zero when good, one on failure
// R20: error on zero-to-one program or timeout
// R21: error clears only on reset command
// R22: window flag zero 120 us after sector erase
// R23: host opens each command with unlock writes; the bench folds them into the command word
// R24: reset command needed after id or error
// R25: idle, non-identifier reads return array data
`include "frs_regs.vh"
module frs_flash_read_status (
	input wire aclk,
	input wire aresetn,

	// register bus, AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,

	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,

	// view of the emulated host port
	output wire [7:0] flash_data_out,
	output wire busy
);
	// counts fixed at build time; the window already carries its margin
	localparam integer WIN_CYC = (`FRS_WIN_NS / `FRS_CLK_NS);
	localparam integer PROT_CYC = (`FRS_PROT_NS / `FRS_CLK_NS);
	// arbitrary value, not any real part's code
	localparam [7:0] ID_CODE = 8'h5A;

	// hold is kept apart from the state so a reset command can cut it
	localparam [1:0] ST_READ = 2'h0;
	localparam [1:0] ST_ID = 2'h1;
	localparam [1:0] ST_PROG = 2'h2;
	localparam [1:0] ST_ERASE = 2'h3;

	// write channel
	reg awready_q;
	reg wready_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg [7:0] awaddr_q;
	reg aw_have_q;
	reg w_have_q;
	// read channel, kept apart so a read never waits on a write
	reg arready_q;
	reg rvalid_q;
	reg [1:0] rresp_q;
	reg [31:0] rdata_q;
	reg [31:0] wdata_q;
	reg [1:0] state_q;
	reg [7:0] mem_data_q;
	reg [7:0] main_prot_q;
	reg [3:0] sec_prot_q;
	reg [7:0] prog_byte_q;
	// status word sources
	reg toggle_q;
	reg error_q;
	reg window_q;
	reg prot_hold_q;
	// sized for the fixed window; a longer window needs more bits
	reg [12:0] win_cnt_q;
	reg [11:0] prot_cnt_q;
	reg [7:0] out_q;
	reg busy_q;
	reg [7:0] fail_q;

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign flash_data_out = out_q;
	assign busy = busy_q;

	// selected sector protected? bus word: [10:8] main sector, [9:8] secondary sector, [12] secondary
	function prot_of;
		input [31:0] w;
		input [7:0] mp;
		input [3:0] sp;
		begin
			if (w[12])
				prot_of = sp[w[9:8]];
			else
				prot_of = mp[w[10:8]];
		end
	endfunction

	// bits 4, 2, 1 and 0 read zero; hosts must not rely on them
	function [7:0] status_word;
		input poll;
		input tog;
		input err;
		input win;
		begin
			status_word = 8'h00;
			status_word[`FRS_BIT_POLL] = poll;
			status_word[`FRS_BIT_TOGGLE] = tog;
			status_word[`FRS_BIT_ERROR] = err;
			status_word[`FRS_BIT_WINDOW] = win;
		end
	endfunction

	// a write completes once address and data are both held
	wire do_write = aw_have_q & w_have_q & ~bvalid_q;
	wire is_bus = do_write && awaddr_q == `FRS_ADDR_BUS;
	wire [2:0] cmd = wdata_q[2:0];
	wire is_cmd = do_write && awaddr_q == `FRS_ADDR_CMD;
	wire tgt_prot = prot_of(wdata_q, main_prot_q, sec_prot_q);
	// no select pins reach this block; every port read counts as selected
	wire any_sel = 1'b1;
	wire op_busy = (state_q == ST_PROG) | (state_q == ST_ERASE);

	// bus read of the emulated parallel port: bit 12 secondary, [1:0] offset
	reg [7:0] port_d;
	always @* begin
		port_d = mem_data_q;
		if (op_busy | prot_hold_q) begin
			// R7: status layout
			port_d = status_word(
				(state_q == ST_PROG) ? ~prog_byte_q[`FRS_BIT_POLL] : 1'b0,
				toggle_q, error_q, window_q);
		end else if (state_q == ST_ID) begin
			// R3: identifier byte
			if (wdata_q[1:0] == `FRS_ID_OFS)
				port_d = ID_CODE;
			// R4: protection byte
			else if (wdata_q[1:0] == `FRS_PROT_OFS)
				port_d = {7'h00, prot_of(wdata_q, main_prot_q, sec_prot_q)};
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `FRS_RESP_OKAY;
			awaddr_q <= 8'h00;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			wdata_q <= 32'h00000000;

			// R1: power-up read-array mode
			state_q <= ST_READ;
			mem_data_q <= `FRS_ERASED;
			main_prot_q <= 8'h00;
			sec_prot_q <= 4'h0;
			prog_byte_q <= 8'h00;
			error_q <= 1'b0;
			window_q <= 1'b1;
			prot_hold_q <= 1'b0;
			win_cnt_q <= 13'h0000;
			prot_cnt_q <= 12'h000;
			fail_q <= 8'h00;
		end else begin
			// address and data are taken in either order
			if (s_axi_awvalid & awready_q) begin
				awaddr_q <= s_axi_awaddr;
				aw_have_q <= 1'b1;
				awready_q <= 1'b0;
			end
			if (s_axi_wvalid & wready_q) begin
				wdata_q <= s_axi_wdata;
				w_have_q <= 1'b1;
				wready_q <= 1'b0;
			end
			// both channels reopen only once the response is taken
			if (bvalid_q & s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end

			// erase window countdown
			if (win_cnt_q != 13'h0000) begin
				win_cnt_q <= win_cnt_q - 13'h0001;
				// R22: window expires
				if (win_cnt_q == 13'h0001)
					window_q <= 1'b1;
			end

			// protected-erase hold countdown
			if (prot_cnt_q != 12'h000) begin
				prot_cnt_q <= prot_cnt_q - 12'h001;
				// R13: all-protected hold ends
				if (prot_cnt_q == 12'h001)
					prot_hold_q <= 1'b0;
			end

			// one write at a time; the pending response holds off the next
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= `FRS_RESP_OKAY;
				case (awaddr_q)
				`FRS_ADDR_CTRL: mem_data_q <= wdata_q[7:0];
				`FRS_ADDR_PROT: begin
					// R5: protection register
					main_prot_q <= wdata_q[7:0];
					sec_prot_q <= wdata_q[11:8];
				end
				`FRS_ADDR_FAIL: fail_q <= wdata_q[7:0];
				`FRS_ADDR_CMD: ;
				`FRS_ADDR_BUS: ;
				default: bresp_q <= `FRS_RESP_SLVERR;
				endcase
			end

			// commands act in the cycle of the write that carries them
			if (is_cmd) begin
				case (cmd)
				`FRS_CMD_PROG: begin
					// R12: protected target ignored
					// R10: polling valid from fourth write
					if (!tgt_prot && state_q == ST_READ) begin
						state_q <= ST_PROG;
						prog_byte_q <= wdata_q[23:16];
						// R20: zero-to-one attempt fails
						if ((wdata_q[23:16] & ~mem_data_q) != 8'h00)
							error_q <= 1'b1;
					end
				end

				`FRS_CMD_SERASE: begin
					// R22: window restarts
					window_q <= 1'b0;
					win_cnt_q <= WIN_CYC[12:0];
					if (tgt_prot) begin
						// R18: all protected, brief toggle
						prot_hold_q <= 1'b1;
						prot_cnt_q <= PROT_CYC[11:0];
					end else
						// R16: toggle valid from sixth write
						state_q <= ST_ERASE;
				end

				`FRS_CMD_BERASE: begin
					if (tgt_prot) begin
						prot_hold_q <= 1'b1;
						prot_cnt_q <= PROT_CYC[11:0];
					end else
						state_q <= ST_ERASE;
				end

				`FRS_CMD_ID: if (!op_busy) state_q <= ST_ID;

				`FRS_CMD_RESET: begin
					// R1: reset command returns to read array
					// R21: error cleared here and by aresetn
					// R24: leaves identifier mode
					state_q <= ST_READ;
					error_q <= 1'b0;
					prot_hold_q <= 1'b0;
					prot_cnt_q <= 12'h000;
				end

				`FRS_CMD_DONE: begin
					// R15: operation ends, data returns
					// R9: stored value becomes true data
					// R11: erased value after erase
					if (state_q == ST_PROG)
						mem_data_q <= mem_data_q & prog_byte_q;
					else if (state_q == ST_ERASE)
						mem_data_q <= `FRS_ERASED;
					if (op_busy)
						state_q <= ST_READ;
				end

				`FRS_CMD_FAIL: begin
					// R19: failure raises error
					if (op_busy)
						error_q <= 1'b1;
				end
				default: ;
				endcase
			end
		end
	end

	// port reads: toggle flips per selected read, busy one cycle late
	always @(posedge aclk) begin
		if (!aresetn) begin
			toggle_q <= 1'b0;
			out_q <= 8'h00;
			busy_q <= 1'b0;
		end else begin
			// busy lags the state by one cycle
			busy_q <= op_busy | prot_hold_q;
			if (is_bus) begin
				// R6: busy read only flips toggle
				// R14: toggle on selected read
				if ((op_busy | prot_hold_q) & any_sel)
					toggle_q <= ~toggle_q;
				out_q <= port_d;
			end
		end
	end

	// read channel, independent of the write side
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= `FRS_RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else begin
			if (s_axi_arvalid & arready_q) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rresp_q <= `FRS_RESP_OKAY;
				case (s_axi_araddr)
				`FRS_ADDR_CTRL: rdata_q <= {24'h000000, mem_data_q};
				`FRS_ADDR_CMD: rdata_q <= 32'h00000000;
				`FRS_ADDR_BUS: rdata_q <= wdata_q;
				// R2: last port read value
				// R25: array data when idle
				`FRS_ADDR_RDATA: rdata_q <= {24'h000000, out_q};
				`FRS_ADDR_STAT: rdata_q <= {24'h000000, prot_hold_q,
					op_busy, 4'h0, state_q};
				`FRS_ADDR_PROT: rdata_q <= {20'h00000, sec_prot_q,
					main_prot_q};
				`FRS_ADDR_FAIL: rdata_q <= {24'h000000, fail_q};
				default: begin
					rdata_q <= 32'h00000000;
					rresp_q <= `FRS_RESP_SLVERR;
				end
				endcase
			end
			// arready returns only after the data is taken
			if (rvalid_q & s_axi_rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end
endmodule // frs_flash_read_status

/* File: logic/frs_regs.vh */
// Purpose: constants for the flash read and status logic
// Assumes: 25 MHz aclk, AXI4-Lite register access
// Notes: byte addresses of the software-visible words
`ifndef FRS_REGS_VH
`define FRS_REGS_VH
`define FRS_ADDR_CTRL 8'h00
`define FRS_ADDR_CMD 8'h04
`define FRS_ADDR_BUS 8'h08
`define FRS_ADDR_RDATA 8'h0C
`define FRS_ADDR_STAT 8'h10
`define FRS_ADDR_PROT 8'h14
`define FRS_ADDR_FAIL 8'h18
`define FRS_CMD_PROG 3'h1
`define FRS_CMD_SERASE 3'h2
`define FRS_CMD_BERASE 3'h3
`define FRS_CMD_ID 3'h4
`define FRS_CMD_RESET 3'h5
`define FRS_CMD_DONE 3'h6
`define FRS_CMD_FAIL 3'h7
`define FRS_BIT_POLL 7
`define FRS_BIT_TOGGLE 6
`define FRS_BIT_ERROR 5
`define FRS_BIT_WINDOW 3
`define FRS_ID_OFS 2'h1
`define FRS_PROT_OFS 2'h2
`define FRS_WIN_NS 120000
`define FRS_PROT_NS 100000
`define FRS_CLK_NS 40
`define FRS_RESP_OKAY 2'h0
`define FRS_RESP_SLVERR 2'h2
`define FRS_ERASED 8'hFF
`endif

/* File: sim/frs_monitor.sv */
// Purpose: port checks of the flash read and status block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the design, sees its ports only
module frs_monitor (
	input wire aclk, aresetn, busy, s_axi_bvalid, s_axi_bready,
	input wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
	input wire [7:0] flash_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_idle: assert property (disable iff (1'b0)
		!aresetn |=> !busy && flash_data_out == 8'h00) else $error("not idle");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid) else $error("no write response");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("no read response");
	a_b_once: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b stuck");
	a_r_once: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r stuck");
	a_busy_cause: assert property ($rose(busy) |->
		$past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("busy early");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("aw ready during response");
	a_port_quiet: assert property (
		$changed(flash_data_out) |-> s_axi_bvalid) else $error("port changed");
	c_busy: cover property ($rose(busy));
	c_done: cover property ($fell(busy));
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // frs_monitor
bind frs_flash_read_status frs_monitor frs_monitor_inst (.*);

/* File: sim/frs_host.sv */
// Purpose: AXI4-Lite master in place of the host controller
// Assumes: the bench calls wr and rd one at a time
// Notes: bready and rready stay high, answers are never stalled
module frs_host (
	input wire aclk, s_axi_awready, s_axi_wready, s_axi_bvalid,
	input wire s_axi_arready, s_axi_rvalid,
	input wire [1:0] s_axi_bresp, s_axi_rresp,
	input wire [31:0] s_axi_rdata,
	output logic [7:0] s_axi_awaddr, s_axi_araddr,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready,
	output logic s_axi_arvalid, s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_wstrb, s_axi_bready, s_axi_rready} = '1;
	end
	task wr(input [7:0] a, input [31:0] d, output [1:0] r);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		// each channel is released at its own handshake
		do begin
			@(posedge aclk);
			aw |= s_axi_awready;
			w |= s_axi_wready;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end while (!(aw && w));
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask
	task rd(input [7:0] a, output [31:0] d, output [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
endmodule // frs_host

/* File: sim/frs_testbench.sv */
// Purpose: self-checking bench of the flash read and status block
// Assumes: the modelled array byte lies in main sector 0
// Notes: waits are bounded by the cycle ceiling
`define CHK(a, e) begin \
	samples_checked++; \
	if ((a) !== (e)) begin \
		bad_count++; \
		$display("wrong value at %0t: %h, expected %h", $time, a, e); \
	end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	wire [7:0] s_axi_awaddr, s_axi_araddr, flash_data_out;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [3:0] s_axi_wstrb;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	wire s_axi_rvalid, s_axi_rready, busy;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [31:0] d;
	logic [1:0] r;
	logic [7:0] v, u;
	frs_flash_read_status frs_flash_read_status_inst (.*);
	frs_host frs_host_inst (.*);
	always #20 aclk = ~aclk;
	task give_verdict;
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// run needs about 6000 cycles, ceiling twice that
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 12000) begin
			bad_count++;
			give_verdict;
		end
	end
	task w(input [7:0] a, input [31:0] c);
		frs_host_inst.wr(a, c, r);
	endtask
	// busy lags the command by one cycle
	// unlock writes are folded into the command word
	task cmd(input [31:0] c);
		w(8'h04, c);
		@(posedge aclk);
	endtask
	// selected read of the polled byte
	task pr(input [1:0] o);
		w(8'h08, {30'h0, o});
		v = flash_data_out;
	endtask
	task t_read;
		w(8'h00, 32'h3C);
		frs_host_inst.rd(8'h00, d, r);
		`CHK(d[7:0], 8'h3C)
		pr(2'h0);
		`CHK(v, 8'h3C)
		frs_host_inst.rd(8'h40, d, r);
		`CHK(r, 2'h2)
	endtask
	task t_id;
		cmd(32'h4);
		pr(2'h1);
		`CHK(v, 8'h5A)
		cmd(32'h5);
		pr(2'h0);
		`CHK(v, 8'h3C)
	endtask
	task t_prog;
		cmd(32'h340001);
		`CHK(busy, 1'b1)
		pr(2'h0);
		u = v;
		`CHK(u[7], 1'b1)
		`CHK(u[5], 1'b0)
		pr(2'h0);
		`CHK(v[6], ~u[6])
		cmd(32'h6);
		`CHK(busy, 1'b0)
		pr(2'h0);
		`CHK(v, 8'h34)
		u = v;
		pr(2'h0);
		`CHK(v, u)
		cmd(32'hFF0001);
		pr(2'h0);
		`CHK(v[5], 1'b1)
		cmd(32'h5);
		pr(2'h0);
		`CHK(v, 8'h34)
	endtask
	task t_erase;
		cmd(32'h2);
		pr(2'h0);
		`CHK(v[7], 1'b0)
		`CHK(v[3], 1'b0)
		repeat (3000) @(posedge aclk);
		pr(2'h0);
		`CHK(v[3], 1'b1)
		cmd(32'h6);
		cmd(32'h3);
		cmd(32'h6);
		pr(2'h0);
		`CHK(v, 8'hFF)
	endtask
	task t_prot;
		w(8'h14, 32'h2);
		frs_host_inst.rd(8'h14, d, r);
		`CHK(d[11:0], 12'h002)
		cmd(32'h104);
		w(8'h08, 32'h102);
		v = flash_data_out;
		`CHK(v, 8'h01)
		cmd(32'h5);
		cmd(32'h101);
		`CHK(busy, 1'b0)
		cmd(32'h102);
		`CHK(busy, 1'b1)
		pr(2'h0);
		`CHK(v[7], 1'b0)
		repeat (2600) @(posedge aclk);
		`CHK(busy, 1'b0)
		pr(2'h0);
		`CHK(v, 8'hFF)
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		`CHK(busy, 1'b0)
		`CHK(flash_data_out, 8'h00)
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_read;
		t_id;
		t_prog;
		t_erase;
		t_prot;
		give_verdict;
	end
endmodule // testbench
